// ===== hw/clk_sel_params.svh
// Contract
// - Holdover exit bandwidth follows bit four.
// - Average window length from 5-bit field.
// - Average window lagged by 5-bit delay.
// - Force bit puts device in holdover.
// - Policy: manual, non-revertive, revertive, reserved.
// - Style bit picks hitless or glitchless switching; zero delay mode blocks hitless.
// - Signal-loss mask bits exclude alarms.
// - Frequency-fault mask bits exclude alarms.
// - Selection outcome can trigger holdover.
// - 3-bit rank per input, zero unselectable.
// - Ranks used only in automatic switching.
// - Lowest rank among available inputs wins.
// - Ties favour input 0,1,2,3.
// - Reference pin source: crystal or external.
// - Enable bits power input buffers.
// - Format bits select pulsed CMOS.
// - Input n uses bits n and n+4.
// - Manual selection from register or pins.
// - Active input number is readable.
`ifndef CLK_SEL_PARAMS_SVH
`define CLK_SEL_PARAMS_SVH
`define ADDR_ACTIVE_INPUT 16'h0507
`define ADDR_INPUT_SELECT 16'h052a
`define ADDR_HOLD_EXIT 16'h052c
`define ADDR_HOLD_LEN 16'h052e
`define ADDR_HOLD_LAG 16'h052f
`define ADDR_HOLD_FORCE 16'h0535
`define ADDR_SWITCH_CTRL 16'h0536
`define ADDR_ALARM_MASKS 16'h0537
`define ADDR_RANK_LOW 16'h0538
`define ADDR_RANK_HIGH 16'h0539
`define ADDR_REF_SOURCE 16'h090e
`define ADDR_IO_THRESH 16'h0943
`define ADDR_INPUT_BUF 16'h0949
`define RAMP_BYPASS_BIT 3
`define EXIT_BW_BIT 4
`define HITLESS_BIT 2
`define ACTIVE_LSB 6
`define RESET_HOLD_EXIT 8'h08
`define RESET_INPUT_BUF 8'h0f
`define RESET_RANKS 8'h21
`define RANK_MAX 3'h4
`define HIST_MAX 6'h3f
`endif

// ===== hw/clk_sel_pkg.sv
package clk_sel_pkg;
    typedef enum logic [1:0] {POLICY_MANUAL, POLICY_NONREV, POLICY_REV,
        POLICY_RSVD} policy_type;
    typedef enum {ST_LOCKED, ST_HOLDOVER} hold_state_type;
endpackage : clk_sel_pkg

// ===== hw/hist_window.sv
`timescale 1ns/1ps
`default_nettype none
`include "clk_sel_params.svh"
module hist_window
    import clk_sel_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic sample_i,
    input wire logic [15:0] freq_i,
    input wire logic [4:0] len_i,
    input wire logic [4:0] lag_i,
    output logic [15:0] avg_o
);
    logic [15:0] hist_reg [0:63];
    logic [21:0] sum;
    always_ff @(posedge core_clk_i)
    begin
        if (sample_i)
        begin
            hist_reg[0] <= freq_i;
            for (int i = 1; i < 64; i++)
                hist_reg[i] <= hist_reg[i-1];
        end
    end
    always_comb
    begin
        sum = 22'h0;
        // Window of len+1 samples starting lag samples into the past.
        for (int i = 0; i < 64; i++)
            if (i >= lag_i && i <= int'(lag_i) + int'(len_i))
                sum = sum + 22'(hist_reg[i]);
    end
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            avg_o <= 16'h0;
        else
            avg_o <= 16'(sum / (22'(len_i) + 22'h1));
    end
endmodule : hist_window
`default_nettype wire

// ===== hw/input_clock_select_holdover_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "clk_sel_params.svh"
module input_clock_select_holdover_ctrl
    import clk_sel_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [3:0] signal_loss_alarm_i,
    input wire logic [3:0] freq_out_of_range_alarm_i,
    input wire logic [1:0] select_pins_i,
    input wire logic zero_delay_enable_i,
    input wire logic freq_sample_i,
    input wire logic [15:0] freq_measure_i,
    output logic [1:0] active_input_indicator_o,
    output logic holdover_o,
    output logic use_fastlock_bw_o,
    output logic phase_buildout_switch_en_o,
    output logic [3:0] input_buffer_en_o,
    output logic [3:0] input_pulsed_cmos_o,
    output logic ref_pin_external_source_sel_o,
    output logic holdover_ramp_bypass_o,
    output logic io_threshold_sel_o,
    output logic [15:0] holdover_freq_o
);
    logic [7:0] holdover_exit_control_reg;
    logic [4:0] holdover_average_length_reg;
    logic [4:0] holdover_average_lag_reg;
    logic holdover_force_control_reg;
    logic [2:0] input_switch_control_reg;
    logic [7:0] input_alarm_masks_reg;
    logic [7:0] input_rank_low_pair_reg;
    logic [7:0] input_rank_high_pair_reg;
    logic reference_pin_source_reg;
    logic io_threshold_select_reg;
    logic [7:0] input_buffer_config_reg;
    logic [2:0] input_select_reg;
    logic [1:0] active_reg;
    logic [1:0] active_next;
    hold_state_type hold_state_reg;
    logic hold_next;
    logic [3:0] healthy;
    logic [3:0] cand;
    logic [11:0] ranks;
    logic found;
    logic [1:0] pick;
    logic [2:0] cur_rank;
    logic [2:0] pick_rank;
    logic [15:0] avg;
    policy_type policy;

    function automatic logic [2:0] rank_of(input logic [11:0] r,
        input logic [1:0] n);
        rank_of = r[n*3 +: 3];
    endfunction : rank_of

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            holdover_exit_control_reg <= `RESET_HOLD_EXIT;
            holdover_average_length_reg <= 5'h0;
            holdover_average_lag_reg <= 5'h0;
            holdover_force_control_reg <= 1'b0;
            input_switch_control_reg <= 3'h0;
            input_alarm_masks_reg <= 8'h0;
            input_rank_low_pair_reg <= `RESET_RANKS;
            input_rank_high_pair_reg <= 8'h0;
            reference_pin_source_reg <= 1'b0;
            io_threshold_select_reg <= 1'b0;
            input_buffer_config_reg <= `RESET_INPUT_BUF;
            input_select_reg <= 3'h0;
        end
        else if (reg_wr_i)
        begin
            case (reg_addr_i)
                `ADDR_HOLD_EXIT: holdover_exit_control_reg <= reg_wdata_i;
                `ADDR_HOLD_LEN: holdover_average_length_reg <= reg_wdata_i[4:0];
                `ADDR_HOLD_LAG: holdover_average_lag_reg <= reg_wdata_i[4:0];
                `ADDR_HOLD_FORCE: holdover_force_control_reg <= reg_wdata_i[0];
                `ADDR_SWITCH_CTRL: input_switch_control_reg <= reg_wdata_i[2:0];
                `ADDR_ALARM_MASKS: input_alarm_masks_reg <= reg_wdata_i;
                `ADDR_RANK_LOW: input_rank_low_pair_reg <= reg_wdata_i;
                `ADDR_RANK_HIGH: input_rank_high_pair_reg <= reg_wdata_i;
                `ADDR_REF_SOURCE: reference_pin_source_reg <= reg_wdata_i[0];
                `ADDR_IO_THRESH: io_threshold_select_reg <= reg_wdata_i[0];
                `ADDR_INPUT_BUF: input_buffer_config_reg <= reg_wdata_i;
                `ADDR_INPUT_SELECT: input_select_reg <= reg_wdata_i[2:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            reg_rdata_o <= 8'h0;
        else if (reg_rd_i)
        begin
            case (reg_addr_i)
                `ADDR_ACTIVE_INPUT: reg_rdata_o <= {active_reg, 6'h0};
                `ADDR_INPUT_SELECT: reg_rdata_o <= {5'h0, input_select_reg};
                `ADDR_HOLD_EXIT: reg_rdata_o <= holdover_exit_control_reg;
                `ADDR_HOLD_LEN: reg_rdata_o <= {3'h0, holdover_average_length_reg};
                `ADDR_HOLD_LAG: reg_rdata_o <= {3'h0, holdover_average_lag_reg};
                `ADDR_HOLD_FORCE: reg_rdata_o <= {7'h0, holdover_force_control_reg};
                `ADDR_SWITCH_CTRL: reg_rdata_o <= {5'h0, input_switch_control_reg};
                `ADDR_ALARM_MASKS: reg_rdata_o <= input_alarm_masks_reg;
                `ADDR_RANK_LOW: reg_rdata_o <= input_rank_low_pair_reg;
                `ADDR_RANK_HIGH: reg_rdata_o <= input_rank_high_pair_reg;
                `ADDR_REF_SOURCE: reg_rdata_o <= {7'h0, reference_pin_source_reg};
                `ADDR_IO_THRESH: reg_rdata_o <= {7'h0, io_threshold_select_reg};
                `ADDR_INPUT_BUF: reg_rdata_o <= input_buffer_config_reg;
                default: reg_rdata_o <= 8'h0;
            endcase
        end
    end

    assign policy = policy_type'(input_switch_control_reg[1:0]);
    assign ranks = {input_rank_high_pair_reg[6:4], input_rank_high_pair_reg[2:0],
        input_rank_low_pair_reg[6:4], input_rank_low_pair_reg[2:0]};

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : gen_health
            // A masked alarm no longer disqualifies its input.
            assign healthy[g] = input_buffer_config_reg[g]
                && !(signal_loss_alarm_i[g] && !input_alarm_masks_reg[g])
                && !(freq_out_of_range_alarm_i[g]
                    && !input_alarm_masks_reg[g+4]);
            assign cand[g] = healthy[g] && ranks[g*3 +: 3] != 3'h0
                && ranks[g*3 +: 3] <= `RANK_MAX;
        end
    endgenerate

    rank_pick u_rank_pick (
        .valid_i(cand),
        .rank_i(ranks),
        .found_o(found),
        .pick_o(pick)
    );

    assign cur_rank = rank_of(ranks, active_reg);
    assign pick_rank = rank_of(ranks, pick);

    always_comb
    begin
        active_next = active_reg;
        hold_next = 1'b0;
        case (policy)
            POLICY_MANUAL:
            begin
                // Ranks are ignored here; the choice is register or pins.
                active_next = input_select_reg[0] ? input_select_reg[2:1]
                    : select_pins_i;
                hold_next = !healthy[active_next];
            end
            POLICY_NONREV:
            begin
                if (!cand[active_reg] && found)
                    active_next = pick;
                hold_next = !found;
            end
            POLICY_REV:
            begin
                if (found && (!cand[active_reg] || pick_rank < cur_rank))
                    active_next = pick;
                hold_next = !found;
            end
            default: hold_next = 1'b0;
        endcase
        if (holdover_force_control_reg)
            hold_next = 1'b1;
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            active_reg <= 2'h0;
            hold_state_reg <= ST_LOCKED;
            use_fastlock_bw_o <= 1'b0;
        end
        else
        begin
            active_reg <= active_next;
            case (hold_state_reg)
                ST_LOCKED:
                begin
                    if (hold_next)
                        hold_state_reg <= ST_HOLDOVER;
                end
                ST_HOLDOVER:
                begin
                    if (!hold_next)
                    begin
                        hold_state_reg <= ST_LOCKED;
                        use_fastlock_bw_o <=
                            !holdover_exit_control_reg[`EXIT_BW_BIT];
                    end
                end
                default: hold_state_reg <= ST_LOCKED;
            endcase
        end
    end

    hist_window u_hist_window (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .sample_i(freq_sample_i && hold_state_reg == ST_LOCKED),
        .freq_i(freq_measure_i),
        .len_i(holdover_average_length_reg),
        .lag_i(holdover_average_lag_reg),
        .avg_o(avg)
    );

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            active_input_indicator_o <= 2'h0;
            holdover_o <= 1'b0;
            phase_buildout_switch_en_o <= 1'b0;
            input_buffer_en_o <= 4'h0;
            input_pulsed_cmos_o <= 4'h0;
            ref_pin_external_source_sel_o <= 1'b0;
            holdover_ramp_bypass_o <= 1'b0;
            io_threshold_sel_o <= 1'b0;
            holdover_freq_o <= 16'h0;
        end
        else
        begin
            active_input_indicator_o <= active_reg;
            holdover_o <= hold_state_reg == ST_HOLDOVER;
            // Zero delay mode cannot carry hitless switching.
            phase_buildout_switch_en_o <=
                input_switch_control_reg[`HITLESS_BIT]
                && !zero_delay_enable_i;
            input_buffer_en_o <= input_buffer_config_reg[3:0];
            input_pulsed_cmos_o <= input_buffer_config_reg[7:4];
            ref_pin_external_source_sel_o <= reference_pin_source_reg;
            holdover_ramp_bypass_o <=
                holdover_exit_control_reg[`RAMP_BYPASS_BIT];
            io_threshold_sel_o <= io_threshold_select_reg;
            if (hold_state_reg == ST_LOCKED)
                holdover_freq_o <= avg;
        end
    end

    force_hold_a: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        holdover_force_control_reg |=> ##1 holdover_o)
        else $error("forced holdover not reached");
    no_input_a: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (policy != POLICY_MANUAL && policy != POLICY_RSVD && !found)
        |=> hold_state_reg == ST_HOLDOVER)
        else $error("no valid input without holdover");
    manual_hold_a: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (policy == POLICY_MANUAL && !healthy[active_next])
        |=> hold_state_reg == ST_HOLDOVER)
        else $error("unhealthy manual input without holdover");
    exit_bw_a: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (hold_state_reg == ST_HOLDOVER && !hold_next)
        |=> use_fastlock_bw_o == !$past(holdover_exit_control_reg[4]))
        else $error("wrong exit bandwidth");
    active_rd_a: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (reg_rd_i && reg_addr_i == `ADDR_ACTIVE_INPUT)
        |=> reg_rdata_o[7:6] == $past(active_reg))
        else $error("active input readback wrong");
    manual_reg_a: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (policy == POLICY_MANUAL && input_select_reg[0])
        |=> active_reg == $past(input_select_reg[2:1]))
        else $error("manual register selection ignored");
    manual_pins_a: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (policy == POLICY_MANUAL && !input_select_reg[0])
        |=> active_reg == $past(select_pins_i))
        else $error("manual pin selection ignored");
    revert_a: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (policy == POLICY_REV && found
            && (!cand[active_reg] || pick_rank < cur_rank))
        |=> active_reg == $past(pick))
        else $error("revertive choice not taken");
    stay_put_a: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (policy == POLICY_NONREV && cand[active_reg])
        |=> active_reg == $past(active_reg))
        else $error("non-revertive switch away from valid input");
    reserved_keep_a: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        (policy == POLICY_RSVD) |=> active_reg == $past(active_reg))
        else $error("reserved policy moved the selection");
    buf_en_a: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        !$past(rst_i)
        |-> input_buffer_en_o == $past(input_buffer_config_reg[3:0]))
        else $error("buffer enables not mirrored");
    ref_src_a: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        !$past(rst_i)
        |-> ref_pin_external_source_sel_o == $past(reference_pin_source_reg))
        else $error("reference source not mirrored");
    hitless_a: assert property (
        @(posedge core_clk_i) disable iff (rst_i)
        phase_buildout_switch_en_o |-> $past(input_switch_control_reg[2]))
        else $error("phase buildout without hitless bit");
endmodule : input_clock_select_holdover_ctrl
`default_nettype wire

// ===== hw/rank_pick.sv
`timescale 1ns/1ps
`default_nettype none
`include "clk_sel_params.svh"
module rank_pick
    import clk_sel_pkg::*;
(
    input wire logic [3:0] valid_i,
    input wire logic [11:0] rank_i,
    output logic found_o,
    output logic [1:0] pick_o
);
    logic [2:0] best;
    always_comb
    begin
        found_o = 1'b0;
        pick_o = 2'h0;
        best = 3'h7;
        for (int i = 0; i < 4; i++)
        begin
            // Strict compare keeps the lower-numbered input on a tie.
            if (valid_i[i] && rank_i[i*3 +: 3] < best)
            begin
                best = rank_i[i*3 +: 3];
                pick_o = 2'(i);
                found_o = 1'b1;
            end
        end
    end
endmodule : rank_pick
`default_nettype wire

// ===== sim/input_clock_select_holdover_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module input_clock_select_holdover_ctrl_tb_top;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic [1:0] pins = 2'h0;
    logic [3:0] los_cmd = 4'h0;
    logic [3:0] oof_cmd = 4'h0;
    logic [15:0] freq_cmd = 16'h0000;
    logic run = 1'b0;
    logic [3:0] signal_loss_alarm, freq_out_of_range_alarm, buf_en, pcmos;
    logic smp, hold, fast, pbo, refx, ramp, iot;
    logic [15:0] meas, hfreq;
    logic [7:0] rdata, d;
    logic [1:0] active;
    int errors = 0;
    int n_compared = 0;
    logic [15:0] addr_list [12] = '{16'h052a, 16'h052c, 16'h052e, 16'h052f,
        16'h0535, 16'h0536, 16'h0537, 16'h0538, 16'h0539, 16'h090e,
        16'h0943, 16'h0949};
    logic [7:0] reset_list [12] = '{8'h00, 8'h08, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h21, 8'h00, 8'h00, 8'h00, 8'h0f};

    always #2.5 core_clk = ~core_clk;

    input_clock_select_holdover_ctrl input_clock_select_holdover_ctrl_inst (
        .core_clk_i(core_clk), .rst_i(rst), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .signal_loss_alarm_i(signal_loss_alarm), .freq_out_of_range_alarm_i(freq_out_of_range_alarm),
        .select_pins_i(pins), .zero_delay_enable_i(1'b0),
        .freq_sample_i(smp), .freq_measure_i(meas),
        .active_input_indicator_o(active), .holdover_o(hold),
        .use_fastlock_bw_o(fast), .phase_buildout_switch_en_o(pbo),
        .input_buffer_en_o(buf_en), .input_pulsed_cmos_o(pcmos),
        .ref_pin_external_source_sel_o(refx),
        .holdover_ramp_bypass_o(ramp), .io_threshold_sel_o(iot),
        .holdover_freq_o(hfreq));

    ref_clock_sources ref_clock_sources_inst (
        .core_clk_i(core_clk), .rst_i(rst), .los_cmd_i(los_cmd),
        .oof_cmd_i(oof_cmd), .freq_cmd_i(freq_cmd), .run_i(run),
        .signal_loss_alarm_o(signal_loss_alarm), .freq_out_of_range_alarm_o(freq_out_of_range_alarm),
        .freq_sample_o(smp), .freq_measure_o(meas));

    task automatic chk_reg(input string what, input logic [7:0] exp,
        input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_reg

    task automatic chk_port(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_port

    task automatic settle();
        repeat (6) @(posedge core_clk);
        #1;
    endtask : settle

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
        @(posedge core_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [15:0] a, output logic [7:0] v);
        @(posedge core_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd <= 1'b0;
        @(posedge core_clk);
        #1;
        v = rdata;
    endtask : rd_reg

    task automatic cfg(input logic [15:0] a, input logic [7:0] v);
        wr_reg(a, v);
        settle();
    endtask : cfg

    task automatic fault(input logic [3:0] l, input logic [3:0] o);
        @(posedge core_clk);
        los_cmd <= l;
        oof_cmd <= o;
        settle();
    endtask : fault

    task automatic samples(input logic [15:0] v, input int n);
        int cnt;
        cnt = 0;
        @(posedge core_clk);
        freq_cmd <= v;
        run <= 1'b1;
        while (cnt < n)
        begin
            @(posedge core_clk);
            if (smp === 1'b1)
                cnt++;
        end
        run <= 1'b0;
        settle();
    endtask : samples

    task automatic t_reset();
        settle();
        for (int i = 0; i < 12; i++)
        begin
            rd_reg(addr_list[i], d);
            chk_reg("reset value", reset_list[i], d);
        end
        chk_port("buffer enables", 16'h000f, buf_en);
        chk_port("ramp bypass", 16'h0001, ramp);
        wr_reg(16'h0600, 8'hff);
        rd_reg(16'h0600, d);
        chk_reg("unmapped", 8'h00, d);
        wr_reg(16'h0507, 8'hff);
        rd_reg(16'h0507, d);
        chk_reg("read only", 8'h00, d);
    endtask : t_reset

    task automatic t_pins();
        cfg(16'h0949, 8'ha5);
        chk_port("buffer enables", 16'h0005, buf_en);
        chk_port("pulsed format", 16'h000a, pcmos);
        cfg(16'h090e, 8'h01);
        chk_port("external ref", 16'h0001, refx);
        cfg(16'h0943, 8'h01);
        chk_port("io threshold", 16'h0001, iot);
        cfg(16'h0949, 8'h0f);
    endtask : t_pins

    task automatic t_auto();
        cfg(16'h0538, 8'h23);
        cfg(16'h0539, 8'h12);
        cfg(16'h0536, 8'h02);
        chk_port("active", 16'h0003, active);
        fault(4'h8, 4'h0);
        chk_port("active", 16'h0001, active);
        cfg(16'h0537, 8'h02);
        fault(4'ha, 4'h0);
        chk_port("active", 16'h0001, active);
        cfg(16'h0537, 8'h00);
        fault(4'h8, 4'h2);
        chk_port("active", 16'h0002, active);
        fault(4'h0, 4'h0);
        chk_port("active", 16'h0003, active);
        cfg(16'h0536, 8'h01);
        fault(4'h8, 4'h0);
        chk_port("active", 16'h0001, active);
        fault(4'h0, 4'h0);
        chk_port("active", 16'h0001, active);
        cfg(16'h0536, 8'h02);
        cfg(16'h0539, 8'h02);
        chk_port("active", 16'h0001, active);
        cfg(16'h0538, 8'h53);
        chk_port("active", 16'h0002, active);
    endtask : t_auto

    task automatic t_hold();
        fault(4'hf, 4'h0);
        chk_port("holdover", 16'h0001, hold);
        fault(4'h0, 4'h0);
        chk_port("holdover", 16'h0000, hold);
        chk_port("fastlock", 16'h0001, fast);
        cfg(16'h052c, 8'h18);
        fault(4'hf, 4'h0);
        fault(4'h0, 4'h0);
        chk_port("fastlock", 16'h0000, fast);
        cfg(16'h0535, 8'h01);
        chk_port("holdover", 16'h0001, hold);
        cfg(16'h0535, 8'h00);
        chk_port("holdover", 16'h0000, hold);
    endtask : t_hold

    task automatic t_manual();
        cfg(16'h0536, 8'h00);
        @(posedge core_clk);
        pins <= 2'h2;
        settle();
        chk_port("active", 16'h0002, active);
        rd_reg(16'h0507, d);
        chk_reg("active field", 8'h80, d);
        cfg(16'h052a, 8'h07);
        chk_port("active", 16'h0003, active);
        fault(4'h8, 4'h0);
        chk_port("holdover", 16'h0001, hold);
        fault(4'h0, 4'h0);
        chk_port("holdover", 16'h0000, hold);
        rd_reg(16'h0507, d);
        chk_reg("active field", 8'hc0, d);
        cfg(16'h0536, 8'h04);
        chk_port("buildout", 16'h0001, pbo);
        cfg(16'h0536, 8'h00);
        chk_port("buildout", 16'h0000, pbo);
        cfg(16'h0536, 8'h03);
        chk_port("active", 16'h0003, active);
        chk_port("holdover", 16'h0000, hold);
    endtask : t_manual

    task automatic t_hist();
        cfg(16'h052e, 8'h03);
        cfg(16'h052f, 8'h02);
        samples(16'h1000, 70);
        chk_port("average", 16'h1000, hfreq);
        samples(16'h2000, 2);
        chk_port("average", 16'h1000, hfreq);
        samples(16'h2000, 4);
        chk_port("average", 16'h2000, hfreq);
    endtask : t_hist

    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    initial
    begin
        repeat (20000) @(posedge core_clk);
        errors++;
        complete_run();
    end

    initial
    begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_pins();
        t_auto();
        t_hold();
        t_manual();
        t_hist();
        complete_run();
    end
endmodule : input_clock_select_holdover_ctrl_tb_top
`default_nettype wire

// ===== sim/ref_clock_sources.sv
`timescale 1ns/1ps
`default_nettype none
module ref_clock_sources
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [3:0] los_cmd_i,
    input wire logic [3:0] oof_cmd_i,
    input wire logic [15:0] freq_cmd_i,
    input wire logic run_i,
    output logic [3:0] signal_loss_alarm_o,
    output logic [3:0] freq_out_of_range_alarm_o,
    output logic freq_sample_o,
    output logic [15:0] freq_measure_o
);
    logic [1:0] phase_reg;
    // Alarms follow the commanded faults one cycle later.
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            signal_loss_alarm_o <= 4'h0;
            freq_out_of_range_alarm_o <= 4'h0;
        end
        else
        begin
            signal_loss_alarm_o <= los_cmd_i;
            freq_out_of_range_alarm_o <= oof_cmd_i;
        end
    end
    // A measurement is offered every fourth cycle; between them the bus
    // carries the inverse so that a stale value is never taken.
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            phase_reg <= 2'h0;
            freq_sample_o <= 1'b0;
            freq_measure_o <= 16'h0000;
        end
        else
        begin
            phase_reg <= phase_reg + 2'h1;
            freq_sample_o <= run_i && (phase_reg == 2'h3);
            freq_measure_o <= (phase_reg == 2'h3) ? freq_cmd_i : ~freq_cmd_i;
        end
    end
endmodule : ref_clock_sources
`default_nettype wire
